// ===== pulse_out_pkg.sv
package pulse_out_pkg;
    // ------------------------------------------------------------
    // Register map (word index = printed offset, data on 16 bits)
    // ------------------------------------------------------------
    localparam logic [15:0] PHASE_A_DELAY_COMP_ADDR  = 16'hE614;
    localparam logic [15:0] PHASE_B_DELAY_COMP_ADDR  = 16'hE615;
    localparam logic [15:0] PHASE_C_DELAY_COMP_ADDR  = 16'hE616;
    localparam logic [15:0] POWER_SIGN_STATUS_ADDR   = 16'hE617;
    localparam logic [15:0] PULSE_OUTPUT_CONFIG_ADDR = 16'hE610;
    localparam logic [15:0] COMPUTATION_MODE_ADDR    = 16'hE60E;
    localparam logic [15:0] MEASUREMENT_MODE_ADDR    = 16'hE700;
    localparam logic [15:0] IRQ_STATUS_ADDR          = 16'hE620;
    localparam logic [15:0] IRQ_MASK_ADDR            = 16'hE621;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PULSE_OUTPUT_CONFIG_RST  = 16'h0E88;
    localparam logic [15:0] COMPUTATION_MODE_RST     = 16'h01FF;
    localparam logic [15:0] DELAY_COMP_RST           = 16'h0000;
    localparam logic [15:0] MEASUREMENT_MODE_RST     = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int QSEL_W           = 3;
    localparam int QSEL_LSB         = 0;
    localparam int DISABLE_LSB      = 9;
    localparam int LATCH_LSB        = 12;
    localparam int PHSEL_LSB        = 0;
    localparam int DELAY_W          = 10;
    localparam int ACT_SIGN_LSB     = 0;
    localparam int SUM_FIRST_BIT    = 3;
    localparam int REACT_SIGN_LSB   = 4;
    localparam int SUM_HIGH_LSB     = 7;
    localparam int ACT_SRC_BIT      = 0;
    localparam int REACT_SRC_BIT    = 1;

    // Delay compensation ranges
    localparam logic [9:0] CURR_ALIAS_LO = 10'h180;
    localparam logic [9:0] VOLT_LO       = 10'h200;
    localparam logic [9:0] VOLT_ALIAS_LO = 10'h380;
    localparam logic [9:0] ALIAS_OFFSET  = 10'h180;

    typedef enum logic [2:0] {
        QTY_TOTAL_ACTIVE   = 3'h0,
        QTY_TOTAL_REACTIVE = 3'h1,
        QTY_APPARENT       = 3'h2,
        QTY_FUND_ACTIVE    = 3'h3,
        QTY_FUND_REACTIVE  = 3'h4
    } quantity_e;
endpackage

// ===== pulse_output_phase_cal_sign_regs.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Third output code 011 selects summed fundamental active power.
// [R2] Third output code 100 selects summed fundamental reactive power.
// [R3] Codes 101, 110, 111 produce no pulses on that output.
// [R4] Disable bits 9..11, default 1, gate pins; converters keep running.
// [R5] Latch bits 12..14, default 0, latch energy on each pulse.
// [R6] Config bit 15 reserved, no effect.
// [R7] Delay value 0..383 compensates the current channel.
// [R8] Delay value 512..895 compensates the voltage channel.
// [R9] Values 384..511 act as 0..127.
// [R10] Values 896..1023 act as 512..639.
// [R11] Delay register bits 15..10 reserved, no effect.
// [R12] Sign bits 0..2 flag negative per-phase active power, source selectable.
// [R13] Sign bits 4..6 flag negative per-phase reactive power, source selectable.
// [R14] Sign bits 3, 7, 8 flag negative summed power of each output path.
// [R15] Path sum uses only selected phases and selected quantity.
// [R16] Sign register bits 15..9 read zero.
// [R17] Codes 000/001/010 select total active, reactive, apparent; defaults 000/001/010.
// [R18] Three phase-select bits per output; set bit includes that phase.
// [R19] Sign bits read-only, updated on each new power result.
module pulse_output_phase_cal_sign_regs
    import pulse_out_pkg::*;
#(
    parameter int PWR_W = 24
) (
    // Clock and reset
    input  wire logic                clk_unused_tie,
    input  wire logic                core_clk,
    input  wire logic                reset,
    // Register port
    input  wire logic [15:0]         regAddr,
    input  wire logic [15:0]         regWrData,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic      [15:0]         regRdData,
    // Power results, one per phase (A,B,C), signed
    input  wire logic                powerValid,
    input  wire logic [3*PWR_W-1:0]  totalActive,
    input  wire logic [3*PWR_W-1:0]  totalReactive,
    input  wire logic [3*PWR_W-1:0]  apparentPower,
    input  wire logic [3*PWR_W-1:0]  fundActive,
    input  wire logic [3*PWR_W-1:0]  fundReactive,
    // Converter pulses, one per output, from the frequency converters
    input  wire logic [2:0]          converterPulse,
    // Pulse outputs and latch strobes
    output logic      [2:0]          freqOut,
    output logic      [2:0]          energyLatch,
    output logic      [2:0]          converterQuantity,
    output logic      [2:0]          converterRun,
    // Sums feeding each converter
    output logic      [3*(PWR_W+2)-1:0] pathSum,
    // Effective compensation per phase: 1 = voltage channel, amount in low bits
    output logic      [2:0]          compVoltage,
    output logic      [3*9-1:0]      compAmount,
    // Interrupt
    output logic                     irq
);
    // Sums carry two guard bits, so the word must leave room for them
    if (PWR_W < 2 || PWR_W > 60) begin : g_bad_width
        $error("PWR_W out of range");
    end

    localparam int SUM_W = PWR_W + 2;

    typedef struct packed {
        logic [15:0]          cfg;
        logic [15:0]          computation_mode_reg;
        logic [15:0]          measMode;
        logic [2:0][15:0]     delayComp;
        logic [8:0]           sign;
        logic [2:0]           irqStatus;
        logic [2:0]           irqMask;
        logic [15:0]          rdData;
        logic [2:0]           freqOut;
        logic [2:0]           latch;
        logic [2:0][SUM_W-1:0] sum;
    } state_s;

    state_s stateReg;
    state_s stateNext;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [SUM_W-1:0] pick(input logic [3*PWR_W-1:0] v, input int p);
        pick = SUM_W'(signed'(v[p*PWR_W +: PWR_W]));
    endfunction

    function automatic logic [3*PWR_W-1:0] quantityBus(input logic [2:0] q);
        unique case (q)
            QTY_TOTAL_ACTIVE:   quantityBus = totalActive;               // [R17]
            QTY_TOTAL_REACTIVE: quantityBus = totalReactive;             // [R17]
            QTY_APPARENT:       quantityBus = apparentPower;             // [R17]
            QTY_FUND_ACTIVE:    quantityBus = fundActive;                // [R1]
            QTY_FUND_REACTIVE:  quantityBus = fundReactive;              // [R2]
            default:            quantityBus = '0;
        endcase
    endfunction

    logic [2:0] qsel [3];
    logic [2:0] qselValid;
    logic [2:0] phSel [3];

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            qsel[k]      = stateReg.cfg[QSEL_LSB + QSEL_W*k +: QSEL_W];
            phSel[k]     = stateReg.computation_mode_reg[PHSEL_LSB + 3*k +: 3];
            qselValid[k] = (qsel[k] <= QTY_FUND_REACTIVE);               // [R3]
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic signed [SUM_W-1:0] acc;
    logic [3*PWR_W-1:0]      qbus;
    logic [8:0]              newSign;
    logic [2:0]              pulseOk;

    always_comb begin
        stateNext = stateReg;
        acc       = '0;
        qbus      = '0;
        newSign   = stateReg.sign;
        pulseOk   = '0;

        // Register writes; sign register has no write path
        if (regWrite) begin                                              // [R19]
            unique case (regAddr)
                PULSE_OUTPUT_CONFIG_ADDR: stateNext.cfg = regWrData;
                COMPUTATION_MODE_ADDR:    stateNext.computation_mode_reg = regWrData;
                MEASUREMENT_MODE_ADDR:    stateNext.measMode = regWrData;
                PHASE_A_DELAY_COMP_ADDR:  stateNext.delayComp[0] = regWrData;
                PHASE_B_DELAY_COMP_ADDR:  stateNext.delayComp[1] = regWrData;
                PHASE_C_DELAY_COMP_ADDR:  stateNext.delayComp[2] = regWrData;
                IRQ_MASK_ADDR:            stateNext.irqMask = regWrData[2:0];
                default: ;
            endcase
        end

        // Sign and path sums refresh on every new power result
        if (powerValid) begin                                            // [R19]
            for (int p = 0; p < 3; p++) begin
                newSign[ACT_SIGN_LSB + p] = stateReg.measMode[ACT_SRC_BIT]
                    ? fundActive[p*PWR_W + PWR_W-1]
                    : totalActive[p*PWR_W + PWR_W-1];                    // [R12]
                newSign[REACT_SIGN_LSB + p] = stateReg.measMode[REACT_SRC_BIT]
                    ? fundReactive[p*PWR_W + PWR_W-1]
                    : totalReactive[p*PWR_W + PWR_W-1];                  // [R13]
            end
            for (int k = 0; k < 3; k++) begin
                acc  = '0;
                qbus = quantityBus(qsel[k]);                             // [R15]
                for (int p = 0; p < 3; p++) begin
                    if (phSel[k][p]) begin                               // [R18]
                        acc = acc + pick(qbus, p);
                    end
                end
                stateNext.sum[k] = acc;
                if (k == 0) begin
                    newSign[SUM_FIRST_BIT] = acc[SUM_W-1];               // [R14]
                end else begin
                    newSign[SUM_HIGH_LSB + k - 1] = acc[SUM_W-1];        // [R14]
                end
            end
            stateNext.sign = newSign;
        end

        // Pin gating; converter keeps counting while pin is disabled
        for (int k = 0; k < 3; k++) begin
            pulseOk[k] = converterPulse[k] && qselValid[k];              // [R3]
            stateNext.freqOut[k] = pulseOk[k] && !stateReg.cfg[DISABLE_LSB + k]; // [R4]
            stateNext.latch[k]   = pulseOk[k] && stateReg.cfg[LATCH_LSB + k];    // [R5]
        end

        // Sticky events: one per output pulse; set wins over read clear
        if (regRead && regAddr == IRQ_STATUS_ADDR) begin
            stateNext.irqStatus = '0;
        end
        stateNext.irqStatus = stateNext.irqStatus | pulseOk;

        // Read data, one cycle later; sign, status and mask upper bits read zero, other registers read back as written
        stateNext.rdData = '0;
        if (regRead) begin
            unique case (regAddr)
                PULSE_OUTPUT_CONFIG_ADDR: stateNext.rdData = stateReg.cfg;
                COMPUTATION_MODE_ADDR:    stateNext.rdData = stateReg.computation_mode_reg;
                MEASUREMENT_MODE_ADDR:    stateNext.rdData = stateReg.measMode;
                PHASE_A_DELAY_COMP_ADDR:  stateNext.rdData = stateReg.delayComp[0];
                PHASE_B_DELAY_COMP_ADDR:  stateNext.rdData = stateReg.delayComp[1];
                PHASE_C_DELAY_COMP_ADDR:  stateNext.rdData = stateReg.delayComp[2];
                POWER_SIGN_STATUS_ADDR:   stateNext.rdData = {7'h00, stateReg.sign}; // [R16]
                IRQ_STATUS_ADDR:          stateNext.rdData = {13'h0000, stateReg.irqStatus};
                IRQ_MASK_ADDR:            stateNext.rdData = {13'h0000, stateReg.irqMask};
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stateReg           <= '0;
            stateReg.cfg       <= PULSE_OUTPUT_CONFIG_RST;              // [R4]
            stateReg.computation_mode_reg  <= COMPUTATION_MODE_RST;
            stateReg.measMode  <= MEASUREMENT_MODE_RST;
            stateReg.delayComp <= {3{DELAY_COMP_RST}};
        end else begin
            stateReg <= stateNext;
        end
    end

    // ------------------------------------------------------------
    // Delay compensation decode (reserved upper bits ignored)
    // ------------------------------------------------------------
    logic [9:0] dval [3];
    logic [9:0] eff  [3];

    always_comb begin
        for (int p = 0; p < 3; p++) begin
            dval[p] = stateReg.delayComp[p][DELAY_W-1:0];                // [R11]
            if (dval[p] >= VOLT_ALIAS_LO) begin
                eff[p] = dval[p] - ALIAS_OFFSET;                         // [R10]
            end else if (dval[p] >= VOLT_LO) begin
                eff[p] = dval[p];                                        // [R8]
            end else if (dval[p] >= CURR_ALIAS_LO) begin
                eff[p] = dval[p] - ALIAS_OFFSET;                         // [R9]
            end else begin
                eff[p] = dval[p];                                        // [R7]
            end
            compVoltage[p]       = eff[p][9];
            compAmount[p*9 +: 9] = eff[p][8:0];
        end
    end

    // ------------------------------------------------------------
    // Outputs (bit 15 of the config is never decoded)
    // ------------------------------------------------------------
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            converterQuantity[k] = 1'b0;
            pathSum[k*SUM_W +: SUM_W] = stateReg.sum[k];
        end
        converterQuantity = qselValid;
        converterRun      = qselValid;                                   // [R6]
    end

    assign regRdData   = stateReg.rdData;
    assign freqOut     = stateReg.freqOut;
    assign energyLatch = stateReg.latch;
    assign irq         = |(stateReg.irqStatus & stateReg.irqMask);
endmodule
`default_nettype wire

// ===== pulse_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_regs_chk
    import pulse_out_pkg::*;
#(
    parameter int PWR_W = 24
) (
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   reset,
    // Register port
    input wire logic [15:0]            regAddr,
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [15:0]            regRdData,
    // Datapath and pins
    input wire logic                   powerValid,
    input wire logic [2:0]             converterPulse,
    input wire logic [2:0]             freqOut,
    input wire logic [2:0]             energyLatch,
    input wire logic [2:0]             converterRun,
    input wire logic [3*(PWR_W+2)-1:0] pathSum,
    input wire logic                   irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    // Status read with no event arriving at the same edge, so set-wins cannot mask it
    sequence s_status_read;
        regRead && regAddr == IRQ_STATUS_ADDR && converterPulse == 3'h0;
    endsequence
    sequence s_irq_cause;
        $past(converterPulse != 3'h0) || $past(regWrite && regAddr == IRQ_MASK_ADDR);
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_read_data_idle: assert property (!regRead |=> regRdData == 16'h0000)
        else $error("read data not zero outside a read");
    a_sign_reserved_zero: assert property (regRead && regAddr == POWER_SIGN_STATUS_ADDR
        |=> regRdData[15:9] == 7'h00)
        else $error("sign register reserved bits not zero");
    a_pulse_has_cause: assert property ((freqOut & ~$past(converterPulse)) == 3'h0)
        else $error("pulse output without converter pulse");
    a_latch_has_cause: assert property ((energyLatch & ~$past(converterPulse)) == 3'h0)
        else $error("latch strobe without converter pulse");
    a_reserved_code_silent: assert property ((freqOut & ~$past(converterRun)) == 3'h0)
        else $error("pulse on output with reserved quantity code");
    a_reserved_code_nolatch: assert property ((energyLatch & ~$past(converterRun)) == 3'h0)
        else $error("latch on output with reserved quantity code");
    a_sums_hold: assert property (!powerValid |=> $stable(pathSum))
        else $error("path sums changed without new power result");
    a_irq_rise_cause: assert property ($rose(irq) |-> s_irq_cause)
        else $error("interrupt rose without event or mask write");
    a_irq_read_clear: assert property (s_status_read |=> !irq)
        else $error("interrupt still high after status read");
endmodule
bind pulse_output_phase_cal_sign_regs pulse_regs_chk #(.PWR_W(PWR_W)) u_chk (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .powerValid(powerValid),
    .converterPulse(converterPulse), .freqOut(freqOut), .energyLatch(energyLatch), .converterRun(converterRun),
    .pathSum(pathSum), .irq(irq));
`default_nettype wire

// ===== pulse_counter_model.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_model (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            reset,
    // Pins watched by the meter controller
    input  wire logic [2:0]      freqOut,
    input  wire logic [2:0]      energyLatch,
    output logic      [2:0][7:0] pulseCount,
    output logic      [2:0][7:0] latchCount
);
    // Pulses are one cycle wide, so counting high samples counts pulses
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            pulseCount[i] <= reset ? 8'h00 : pulseCount[i] + 8'(freqOut[i]);
            latchCount[i] <= reset ? 8'h00 : latchCount[i] + 8'(energyLatch[i]);
        end
    end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errTotal++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
    import pulse_out_pkg::*;
    logic            core_clk, reset, regWrite, regRead, powerValid, irq;
    logic [15:0]     regAddr, regWrData, regRdData;
    logic [71:0]     totalActive, totalReactive, apparentPower, fundActive, fundReactive;
    logic [2:0]      converterPulse, freqOut, energyLatch, converterQuantity, converterRun, compVoltage;
    logic [77:0]     pathSum;
    logic [26:0]     compAmount;
    logic [2:0][7:0] pulseCount, latchCount;
    int              errTotal = 0, checksDone = 0, cycles = 0;
    pulse_output_phase_cal_sign_regs dut (.clk_unused_tie(1'b0), .core_clk(core_clk), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .powerValid(powerValid), .totalActive(totalActive), .totalReactive(totalReactive),
        .apparentPower(apparentPower), .fundActive(fundActive), .fundReactive(fundReactive),
        .converterPulse(converterPulse), .freqOut(freqOut), .energyLatch(energyLatch),
        .converterQuantity(converterQuantity), .converterRun(converterRun), .pathSum(pathSum),
        .compVoltage(compVoltage), .compAmount(compAmount), .irq(irq));
    pulse_counter_model partner (.core_clk(core_clk), .reset(reset), .freqOut(freqOut),
        .energyLatch(energyLatch), .pulseCount(pulseCount), .latchCount(latchCount));
    // ----------------------------------------
    // Bus and pulse helpers
    // ----------------------------------------
    // Each helper lets at least one idle edge pass so no strobe is assigned twice in a time step
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 `CHK(regRdData, e);
        @(posedge core_clk);
    endtask
    task automatic pulse(input logic [2:0] p, input logic [2:0] expF, input logic [2:0] expL);
        converterPulse <= p;
        @(posedge core_clk);
        converterPulse <= 3'h0;
        #1 `CHK({freqOut, energyLatch}, {expF, expL});
        @(posedge core_clk);
    endtask
    task automatic new_power();
        powerValid <= 1'b1;
        @(posedge core_clk);
        powerValid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        rdchk(PULSE_OUTPUT_CONFIG_ADDR, 16'h0E88);
        for (int i = 0; i < 3; i++) rdchk(PHASE_A_DELAY_COMP_ADDR + 16'(i), 16'h0000);
        rdchk(POWER_SIGN_STATUS_ADDR, 16'h0000);
        rdchk(COMPUTATION_MODE_ADDR, 16'h01FF);
        rdchk(16'h0000, 16'h0000);
        $display("reset values test done");
    endtask
    task automatic test_enable();
        pulse(3'h7, 3'h0, 3'h0);
        wr(PULSE_OUTPUT_CONFIG_ADDR, 16'h0088);
        pulse(3'h7, 3'h7, 3'h0);
        wr(PULSE_OUTPUT_CONFIG_ADDR, 16'hF088);
        pulse(3'h7, 3'h7, 3'h7);
        // The counters take the last pulse at this edge; let them settle first
        #1 `CHK({pulseCount[0], latchCount[2]}, 16'h0201);
        $display("enable and latch test done");
    endtask
    task automatic test_codes();
        logic run;
        for (int c = 0; c < 8; c++) begin
            wr(PULSE_OUTPUT_CONFIG_ADDR, 16'(c << 6) | 16'h0008);
            run = (c < 5);
            `CHK({converterQuantity[2], converterRun[2]}, {run, run});
            pulse(3'h4, {run, 2'b00}, 3'h0);
        end
        $display("quantity code test done");
    endtask
    task automatic test_delay();
        logic [9:0] vals [8] = '{10'h000, 10'h17F, 10'h180, 10'h1FF, 10'h200, 10'h37F, 10'h380, 10'h3FF};
        logic [8:0] m;
        for (int i = 0; i < 8; i++) begin
            wr(PHASE_A_DELAY_COMP_ADDR + 16'(i % 3), {6'h00, vals[i]});
            m = (vals[i][8:0] >= 9'h180) ? vals[i][8:0] - 9'h180 : vals[i][8:0];
            `CHK(compVoltage[i % 3], vals[i][9]);
            `CHK(compAmount[9 * (i % 3) +: 9], m);
            rdchk(PHASE_A_DELAY_COMP_ADDR + 16'(i % 3), {6'h00, vals[i]});
        end
        wr(PHASE_A_DELAY_COMP_ADDR, 16'hFC05);
        `CHK({compVoltage[0], compAmount[8:0]}, 10'h005);
        $display("delay compensation test done");
    endtask
    task automatic test_sign();
        totalActive <= {24'h00_0004, 24'h00_0003, 24'hFF_FFFB};
        totalReactive <= {24'h00_0001, 24'hFF_FFF9, 24'h00_0002};
        apparentPower <= {3{24'h00_0006}};
        fundActive <= {24'hFF_FFFF, 24'hFF_FFFF, 24'h00_0001};
        fundReactive <= {24'h00_0001, 24'h00_0001, 24'hFF_FFFF};
        wr(PULSE_OUTPUT_CONFIG_ADDR, 16'h0E88);
        new_power();
        rdchk(POWER_SIGN_STATUS_ADDR, 16'h00A1);
        `CHK(pathSum, {26'h000_0012, 26'h3FF_FFFC, 26'h000_0002});
        wr(POWER_SIGN_STATUS_ADDR, 16'hFFFF);
        rdchk(POWER_SIGN_STATUS_ADDR, 16'h00A1);
        wr(COMPUTATION_MODE_ADDR, 16'h01F9);
        wr(MEASUREMENT_MODE_ADDR, 16'h0003);
        new_power();
        rdchk(POWER_SIGN_STATUS_ADDR, 16'h009E);
        `CHK(pathSum[25:0], 26'h3FF_FFFB);
        wr(PULSE_OUTPUT_CONFIG_ADDR, 16'h00C8);
        new_power();
        `CHK(pathSum[77:52], 26'h3FF_FFFF);
        wr(PULSE_OUTPUT_CONFIG_ADDR, 16'h0108);
        new_power();
        `CHK(pathSum[77:52], 26'h000_0001);
        $display("power sign test done");
    endtask
    task automatic test_irq();
        wr(PULSE_OUTPUT_CONFIG_ADDR, 16'h0088);
        rdchk(IRQ_STATUS_ADDR, 16'h0007);
        wr(IRQ_MASK_ADDR, 16'h0001);
        pulse(3'h1, 3'h1, 3'h0);
        `CHK(irq, 1'b1);
        rdchk(IRQ_STATUS_ADDR, 16'h0001);
        `CHK(irq, 1'b0);
        pulse(3'h2, 3'h2, 3'h0);
        `CHK(irq, 1'b0);
        rdchk(IRQ_STATUS_ADDR, 16'h0002);
        $display("interrupt test done");
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // The run needs well under a thousand cycles; the ceiling leaves ample margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            completeRun();
        end
    end
    initial begin
        {reset, regWrite, regRead, powerValid, converterPulse} = 7'h40;
        {regAddr, regWrData} = 32'h0000_0000;
        {totalActive, totalReactive, apparentPower, fundActive, fundReactive} = '0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        test_reset();
        test_enable();
        test_codes();
        test_delay();
        test_sign();
        test_irq();
        completeRun();
    end
endmodule
`default_nettype wire
